// [sim/udb_chk.sv]
// link pin checker for the data-in burst pair
`timescale 1ns/1ns
module udb_chk (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic dmarq,
  input wire logic dmack_n,
  input wire logic stop,
  input wire logic hdmardy_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dstrobe_oe,
  input wire logic dstrobe,
  input wire logic dd_dev_oe,
  input wire udb_pkg::udb_word_t dd
);
  import udb_pkg::*;
  logic strobe_q;
  logic fell_q;
  logic [3:0] gap_q;
  logic [3:0] fgap_q;
  logic [3:0] rdy_q;
  // strobe activity and host setup decode
  wire chg_w = dstrobe != strobe_q;
  wire edge_w = chg_w && dd_dev_oe;
  wire setup_w = stop && hdmardy_n && cs0_n && cs1_n && (da == 3'h0);
  // edge spacing, first fall seen and host pause age
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      strobe_q <= 1'b1;
      fell_q <= 1'b0;
      gap_q <= 4'hf;
      fgap_q <= 4'hf;
      rdy_q <= 4'h0;
    end else begin
      strobe_q <= dstrobe;
      fell_q <= !dmack_n && (fell_q || (chg_w && !dstrobe));
      gap_q <= chg_w ? 4'h0 : gap_q + {3'h0, gap_q != 4'hf};
      fgap_q <= (chg_w && !dstrobe) ? 4'h0 : fgap_q + {3'h0, fgap_q != 4'hf};
      rdy_q <= hdmardy_n ? rdy_q + {3'h0, rdy_q != 4'hf} : 4'h0;
    end
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence host_ready_s;
    !stop && !hdmardy_n;
  endsequence
  req_idle_a: assert property ($rose(dmarq) |-> dmack_n)
    else $error("request raised under acknowledge");
  req_hold_a: assert property ($fell(dmarq) |-> fell_q)
    else $error("request dropped before first strobe fall");
  ack_setup_a: assert property ($fell(dmack_n) |-> $past(setup_w) && $past(setup_w, 2))
    else $error("acknowledge without settled setup");
  sel_quiet_a: assert property (!dmack_n |-> cs0_n && cs1_n && da == 3'h0)
    else $error("selects active during burst");
  ack_hold_a: assert property ($rose(dmack_n) |-> $past(stop && !dmarq))
    else $error("acknowledge dropped mid burst");
  strobe_own_a: assert property ($changed(dstrobe_oe) |-> $past(dmack_n) != dstrobe_oe)
    else $error("strobe drive not tied to acknowledge");
  env_ready_a: assert property ($fell(dmack_n) |-> ##[1:2] host_ready_s)
    else $error("host ready late after acknowledge");
  drive_after_a: assert property ($rose(dd_dev_oe) |-> $past(!dmack_n && !stop && !hdmardy_n))
    else $error("data driven before host ready");
  word_setup_a: assert property (edge_w |-> $stable(dd) && $past(dd, 2) == dd)
    else $error("strobe edge too soon after data");
  edge_space_a: assert property (edge_w |-> gap_q >= 4'h3 && (dstrobe || fgap_q >= 4'h7))
    else $error("strobe edges too close");
  word_hold_a: assert property (edge_w |=> $stable(dd))
    else $error("data changed right after edge");
  pause_halt_a: assert property (edge_w && hdmardy_n |-> rdy_q < 4'h4)
    else $error("strobe edge long after host pause");
endmodule // udb_chk

// [sim/udma_data_in_burst_tb_top.sv]
// self-checking bench of the device and host burst ends
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module udma_data_in_burst_tb_top;
  import udb_pkg::*;
  logic clk, rst, start, end_r, dval, dready, dbusy, ddone, crcerr;
  logic hen, hstop, hvalid, hready, hbusy, hdone;
  logic [1:0] hcs;
  logic [2:0] hda;
  udb_word_t ddata, hdata, w;
  udb_word_t exp_q[$];
  int error_cnt, checks, rx_n, want;
  wire [3:0] ev = {dready, rx_n >= want, hdone, ddone};
  udb_if lnk();
  udb_device udb_device_i (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .LINK(lnk.dev), .START_IN(start),
    .END_IN(end_r), .DATA_IN(ddata), .VALID_IN(dval), .READY_OUT(dready), .BUSY_OUT(dbusy),
    .DONE_OUT(ddone), .CRC_ERR_OUT(crcerr));
  udb_host udb_host_i (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .LINK(lnk.host), .ENABLE_IN(hen),
    .STOP_REQ_IN(hstop), .CS_N_IN(hcs), .DA_IN(hda), .DATA_OUT(hdata), .VALID_OUT(hvalid),
    .READY_IN(hready), .BUSY_OUT(hbusy), .DONE_OUT(hdone));
  udb_chk udb_chk_i (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .dmarq(lnk.dmarq), .dmack_n(lnk.dmack_n),
    .stop(lnk.stop), .hdmardy_n(lnk.hdmardy_n), .cs0_n(lnk.cs0_n), .cs1_n(lnk.cs1_n), .da(lnk.da),
    .dstrobe_oe(lnk.dstrobe_oe), .dstrobe(lnk.dstrobe), .dd_dev_oe(lnk.dd_dev_oe), .dd(lnk.dd));
  task automatic test_done();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for one event bit
  task automatic wait_ev(input int b);
    int k;
    k = 0;
    while (ev[b] !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    if (k == 3000) begin
      error_cnt++;
      $display("ERROR %0t wait ran out", $time);
      test_done();
    end
  endtask
  // hand n words to the device, with one idle gap after six
  task automatic send(input int n, input udb_word_t base);
    for (int i = 0; i < n; i++) begin
      if (i == 6) begin
        dval = 1'b0;
        tick(30);
      end
      ddata = base + 16'(i);
      dval = 1'b1;
      exp_q.push_back(ddata);
      wait_ev(3);
      tick(1);
    end
    dval = 1'b0;
  endtask
  task automatic burst_start();
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask
  // bounded wait for both end-of-burst pulses
  task automatic wait_done();
    fork
      wait_ev(0);
      wait_ev(1);
    join
  endtask
  // compare host output words in sent order
  always @(posedge clk) begin
    if (hvalid === 1'b1 && hready === 1'b1) begin
      w = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
      `CHK(hdata, w)
      rx_n++;
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    start = 1'b0;
    end_r = 1'b0;
    dval = 1'b0;
    ddata = 16'h0000;
    hen = 1'b1;
    hstop = 1'b0;
    hcs = 2'h0;
    hda = 3'h5;
    hready = 1'b0;
    error_cnt = 0;
    checks = 0;
    rx_n = 0;
    want = 0;
    tick(6);
    rst = 1'b0;
    `CHK(lnk.dmack_n, 1'b1)
    `CHK(lnk.dmarq, 1'b0)
    // device-ended burst, host fifo stalled, device gap
    burst_start();
    `CHK(dbusy, 1'b1)
    fork
      send(20, 16'h5a00);
      begin
        tick(400);
        hready = 1'b1;
      end
    join
    want = 20;
    wait_ev(2);
    end_r = 1'b1;
    tick(1);
    end_r = 1'b0;
    wait_done();
    tick(2);
    `CHK(dbusy, 1'b0)
    `CHK(hbusy, 1'b0)
    `CHK(crcerr, 1'b0)
    `CHK(rx_n, 20)
    // host-ended burst with words across the float value
    burst_start();
    `CHK(dbusy, 1'b1)
    send(5, 16'hfffd);
    want = 25;
    wait_ev(2);
    hstop = 1'b1;
    tick(1);
    hstop = 1'b0;
    wait_done();
    tick(10);
    `CHK(dbusy, 1'b0)
    `CHK(hbusy, 1'b0)
    `CHK(crcerr, 1'b0)
    `CHK(rx_n, 25)
    `CHK(lnk.cs0_n, 1'b0)
    `CHK(lnk.da, 3'h5)
    test_done();
  end
endmodule // udma_data_in_burst_tb_top

// [verilog/udb_cfg.svh]
// timing figures, cycle counts and fixed values of the data-in burst link
`ifndef UDB_CFG_SVH
`define UDB_CFG_SVH

// core clock period
`define UDB_CLK_NS 20
// least times round up to whole cycles, longest times round down
`define UDB_MIN_CYC(ns) (((ns) + `UDB_CLK_NS - 1) / `UDB_CLK_NS)
`define UDB_MAX_CYC(ns) ((ns) / `UDB_CLK_NS)

// link timing figures in ns
`define UDB_T_ACK_NS 40
`define UDB_T_ZIORDY_NS 20
`define UDB_T_ZAD_NS 20
`define UDB_T_DVS_NS 40
`define UDB_T_DVH_NS 40
`define UDB_T_CYC_NS 80
`define UDB_T_2CYC_NS 160
`define UDB_T_SS_NS 60
`define UDB_T_RFS_NS 60
`define UDB_T_RP_NS 160
`define UDB_T_ZAH_NS 40
`define UDB_T_MLI_NS 40

// derived cycle counts
`define UDB_ACK_CYC `UDB_MIN_CYC(`UDB_T_ACK_NS)
`define UDB_ZIORDY_CYC `UDB_MIN_CYC(`UDB_T_ZIORDY_NS)
`define UDB_ZAD_CYC `UDB_MIN_CYC(`UDB_T_ZAD_NS)
`define UDB_DVS_CYC `UDB_MIN_CYC(`UDB_T_DVS_NS)
`define UDB_DVH_CYC `UDB_MIN_CYC(`UDB_T_DVH_NS)
`define UDB_CYC_CYC `UDB_MIN_CYC(`UDB_T_CYC_NS)
`define UDB_2CYC_CYC `UDB_MIN_CYC(`UDB_T_2CYC_NS)
`define UDB_SS_CYC `UDB_MIN_CYC(`UDB_T_SS_NS)
`define UDB_RFS_CYC `UDB_MAX_CYC(`UDB_T_RFS_NS)
`define UDB_RP_CYC `UDB_MIN_CYC(`UDB_T_RP_NS)
`define UDB_ZAH_CYC `UDB_MIN_CYC(`UDB_T_ZAH_NS)
`define UDB_MLI_CYC `UDB_MIN_CYC(`UDB_T_MLI_NS)

// data path values
`define UDB_CRC_SEED 16'hffff
`define UDB_CRC_POLY 16'h1021
`define UDB_DD_IDLE 16'hffff
`define UDB_FIFO_DEPTH 8
`define UDB_MODE 4

`endif

// [verilog/udb_device.sv]
// storage device end of the data-in burst, with the shared pin synchroniser
`timescale 1ns/1ns
`include "udb_cfg.svh"

// two-flop synchroniser for a group of pins
module udb_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q <= d_in; // load pin levels, so no false edge after reset
      s2_q <= d_in;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end

  assign q_out = s2_q;
endmodule // udb_sync

// Function
// - host keeps acknowledge negated before a burst
// - request only while acknowledge negated, hold it
// - host sets stop, ready, address before acknowledge
// - host keeps selects negated all burst long
// - host holds acknowledge until burst ends
// - host releases data bus after acknowledge
// - strobe driven after acknowledge, until its negation
// - host flips stop and ready, holds them
// - drive bus only after ready conditions settle
// - first word by strobe negation after setup
// - each later word by strobe toggle
// - strobe edges respect single and double cycle
// - hold data after each latching edge
// - repeat word cycles until pause or end
// - no pause before the first word
// - device pauses by withholding strobe edges
// - host pauses and resumes through its ready
// - stop strobing soon after host not ready
// - host absorbs two or three trailing words
// - latch host crc on acknowledge negation
module udb_device (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  udb_if.dev LINK,
  input wire logic START_IN,
  input wire logic END_IN,
  input wire udb_pkg::udb_word_t DATA_IN,
  input wire logic VALID_IN,
  output logic READY_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic CRC_ERR_OUT
);
  import udb_pkg::*;

  localparam udb_cnt_t ZIO_C = 8'(`UDB_ZIORDY_CYC);
  localparam udb_cnt_t ZAD_C = 8'(`UDB_ZAD_CYC);
  localparam udb_cnt_t DVS_C = 8'(`UDB_DVS_CYC);
  localparam udb_cnt_t DVH_C = 8'(`UDB_DVH_CYC);
  localparam udb_cnt_t CYC_C = 8'(`UDB_CYC_CYC);
  localparam udb_cnt_t TWO_C = 8'(`UDB_2CYC_CYC);
  localparam udb_cnt_t SS_C = 8'(`UDB_SS_CYC);

  // the ready pin needs two sync cycles plus one decision cycle
  if (`UDB_RFS_CYC < 3) begin : g_bad_rfs
    $error("strobe stop time too short for synchronised ready");
  end
  if (`UDB_2CYC_CYC > 255 || `UDB_SS_CYC > 255) begin : g_bad_cnt
    $error("timing count exceeds counter width");
  end

  udb_dev_e state_q;
  udb_dev_e state_d;
  logic [18:0] sync_w;
  logic dmack_n_p_q;
  logic dmarq_q;
  logic stb_q;
  logic stb_oe_q;
  udb_word_t dd_q;
  logic dd_oe_q;
  logic pend_q;
  logic sent_q;
  logic end_q;
  udb_cnt_t cnt_q;
  udb_cnt_t edge_age_q;
  udb_cnt_t gap_q;
  udb_cnt_t data_age_q;
  udb_word_t crc_q;
  logic crc_err_q;
  logic done_q;
  logic busy_q;

  // pins from the host domain
  udb_sync #(
    .W(19)
  ) u_sync (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in({LINK.dmack_n, LINK.stop, LINK.hdmardy_n, LINK.dd}),
    .q_out(sync_w)
  );

  // synchronised pin views and decode
  wire dmack_n_s = sync_w[18];
  wire stop_s = sync_w[17];
  wire hrdy_n_s = sync_w[16];
  wire [15:0] dd_s = sync_w[15:0];
  wire dmack_rise = dmack_n_s & ~dmack_n_p_q;
  wire in_run = (state_q == D_RUN);
  wire [8:0] pair_age = {1'b0, edge_age_q} + {1'b0, gap_q};
  wire can_load = in_run & ~pend_q & (edge_age_q >= DVH_C);
  wire load = can_load & VALID_IN;
  wire gap_ok = (edge_age_q >= CYC_C) & (pair_age >= {1'b0, TWO_C});
  // no edge while host not ready
  wire fire = in_run & pend_q & ~hrdy_n_s & ~stop_s & (data_age_q >= DVS_C) & gap_ok;
  // device end only after a word
  wire dev_end = in_run & end_q & sent_q & ~pend_q;
  wire leave = (state_d != state_q);

  // burst sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      D_IDLE: begin
        if (START_IN & dmack_n_s) begin
          state_d = D_REQ;
        end
      end
      D_REQ: begin
        if (~dmack_n_s & (cnt_q >= ZIO_C)) begin
          state_d = D_ARM;
        end
      end
      D_ARM: begin
        // bus driven after stop and ready settle
        if (~stop_s & ~hrdy_n_s & ~dmack_n_s & (cnt_q >= ZAD_C)) begin
          state_d = D_RUN;
        end
      end
      D_RUN: begin
        // word cycles run until an end
        if (stop_s & sent_q) begin
          state_d = D_TERM;
        end else if (dev_end) begin
          state_d = D_DRAIN;
        end
      end
      D_DRAIN: begin
        if (stop_s | (edge_age_q >= SS_C)) begin
          state_d = D_TERM;
        end
      end
      D_TERM: begin
        if (dmack_rise) begin
          state_d = D_IDLE;
        end
      end
      default: begin
        state_d = D_IDLE;
      end
    endcase
  end

  // state and phase timer
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_q <= D_IDLE;
      cnt_q <= '0;
      dmack_n_p_q <= 1'b1;
    end else begin
      state_q <= state_d;
      dmack_n_p_q <= dmack_n_s;
      if (leave | (state_q == D_REQ & dmack_n_s) | (state_q == D_ARM & (stop_s | hrdy_n_s))) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= udb_sat_inc(cnt_q);
      end
    end
  end

  // pin drivers follow the next state
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      dmarq_q <= 1'b0;
      stb_oe_q <= 1'b0;
      dd_oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      dmarq_q <= (state_d == D_REQ) | (state_d == D_ARM) | (state_d == D_RUN) |
                 (state_d == D_DRAIN);
      // strobe kept driven until acknowledge negates
      stb_oe_q <= (state_d == D_ARM) | (state_d == D_RUN) | (state_d == D_DRAIN) |
                  (state_d == D_TERM);
      dd_oe_q <= (state_d == D_RUN) | (state_d == D_DRAIN);
      busy_q <= (state_d != D_IDLE);
    end
  end

  // strobe level
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      stb_q <= 1'b1;
    end else if (state_q == D_REQ) begin
      stb_q <= 1'b1;
    end else if (fire) begin
      stb_q <= ~stb_q;
    end else if (state_q == D_TERM & stop_s) begin
      stb_q <= 1'b1; // non-data assertion at termination
    end
  end

  // word register and pending flag
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      dd_q <= '0;
      pend_q <= 1'b0;
    end else begin
      if (load) begin
        dd_q <= DATA_IN;
      end
      // no word pending means a pause
      pend_q <= in_run & (load | (pend_q & ~fire));
    end
  end

  // edge and data age counters
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      edge_age_q <= '1;
      gap_q <= '1;
      data_age_q <= '0;
    end else if (state_q == D_IDLE) begin
      edge_age_q <= '1;
      gap_q <= '1;
      data_age_q <= '0;
    end else begin
      edge_age_q <= fire ? '0 : udb_sat_inc(edge_age_q);
      if (fire) begin
        gap_q <= edge_age_q;
      end
      data_age_q <= load ? '0 : udb_sat_inc(data_age_q);
    end
  end

  // burst bookkeeping and crc
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      sent_q <= 1'b0;
      end_q <= 1'b0;
      crc_q <= `UDB_CRC_SEED;
    end else begin
      end_q <= END_IN | (end_q & ~(state_q == D_TERM & dmack_rise));
      if (state_q == D_IDLE) begin
        sent_q <= 1'b0;
        crc_q <= `UDB_CRC_SEED;
      end else if (fire) begin
        sent_q <= 1'b1;
        crc_q <= udb_crc_next(crc_q, dd_q);
      end
    end
  end

  // crc check at burst end
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      crc_err_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == D_TERM) & dmack_rise;
      // host crc taken as acknowledge negates
      if ((state_q == D_TERM) & dmack_rise & (dd_s != crc_q)) begin
        crc_err_q <= 1'b1;
      end else if ((state_q == D_IDLE) & START_IN) begin
        crc_err_q <= 1'b0;
      end
    end
  end

  // outputs
  assign LINK.dmarq = dmarq_q;
  assign LINK.dstrobe_o = stb_q;
  assign LINK.dstrobe_oe = stb_oe_q;
  assign LINK.dd_dev_o = dd_q;
  assign LINK.dd_dev_oe = dd_oe_q;
  assign READY_OUT = can_load;
  assign BUSY_OUT = busy_q;
  assign DONE_OUT = done_q;
  assign CRC_ERR_OUT = crc_err_q;
endmodule // udb_device

// [verilog/udb_host.sv]
// host end of the data-in burst with its receive fifo
`timescale 1ns/1ns
`include "udb_cfg.svh"

// flip-flop fifo with valid and ready on both sides
module udb_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] lvl_q;

  // handshake decode
  assign in_ready_out = (lvl_q != (AW + 1)'(DEPTH));
  assign out_valid_out = (lvl_q != '0);
  wire wr = in_valid_in & in_ready_out;
  wire rd = out_valid_out & out_ready_in;

  // pointers and fill level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      lvl_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(wr);
      rd_q <= rd_q + AW'(rd);
      lvl_q <= lvl_q + (AW + 1)'(wr) - (AW + 1)'(rd);
    end
  end

  // storage
  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  assign out_data_out = mem_q[rd_q];
  assign level_out = lvl_q;
endmodule // udb_fifo

module udb_host #(
  parameter int unsigned MODE = `UDB_MODE,
  parameter int unsigned DEPTH = `UDB_FIFO_DEPTH
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  udb_if.host LINK,
  input wire logic ENABLE_IN,
  input wire logic STOP_REQ_IN,
  input wire logic [1:0] CS_N_IN,
  input wire logic [2:0] DA_IN,
  output udb_pkg::udb_word_t DATA_OUT,
  output logic VALID_OUT,
  input wire logic READY_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT
);
  import udb_pkg::*;

  // trailing words the fifo must absorb
  localparam int unsigned EXTRA = (MODE >= 3) ? 3 : 2;
  localparam int unsigned LW = $clog2(DEPTH) + 1;
  localparam udb_cnt_t ACK_C = 8'(`UDB_ACK_CYC);
  localparam udb_cnt_t RP_C = 8'(`UDB_RP_CYC);
  localparam udb_cnt_t ZAH_C = 8'(`UDB_ZAH_CYC);
  localparam udb_cnt_t MLI_C = 8'(`UDB_MLI_CYC);

  if (MODE > 6 || DEPTH < EXTRA + 2) begin : g_bad_cfg
    $error("mode above 6 or fifo too shallow for trailing words");
  end

  udb_host_e state_q;
  udb_host_e state_d;
  logic [17:0] sync_w;
  logic stb_p_q;
  logic first_q;
  logic stop_req_q;
  udb_cnt_t cnt_q;
  logic dmack_n_q;
  logic stop_q;
  logic hrdy_n_q;
  logic [1:0] cs_n_q;
  logic [2:0] da_q;
  udb_word_t dd_q;
  logic dd_oe_q;
  udb_word_t crc_q;
  logic done_q;
  logic [LW-1:0] level;

  // pins from the device domain
  udb_sync #(
    .W(18)
  ) u_sync (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in({LINK.dmarq, LINK.dstrobe, LINK.dd}),
    .q_out(sync_w)
  );

  // edge decode and receive gating
  wire dmarq_s = sync_w[17];
  wire stb_s = sync_w[16];
  wire stb_edge = stb_s ^ stb_p_q;
  // every edge carries a word in run and in the termination pause
  wire take = stb_edge & ((state_q == H_RUN) | (state_q == H_TPAUSE));
  wire space_ok = (level <= LW'(DEPTH - 1 - EXTRA));
  wire leave = (state_d != state_q);

  udb_fifo #(
    .W(16),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .in_valid_in(take),
    .in_ready_out(),
    .in_data_in(sync_w[15:0]),
    .out_valid_out(VALID_OUT),
    .out_ready_in(READY_IN),
    .out_data_out(DATA_OUT),
    .level_out(level)
  );

  // burst sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      H_IDLE: if (ENABLE_IN & dmarq_s) begin
        state_d = H_SETUP;
      end
      H_SETUP: if (cnt_q >= ACK_C) begin
        state_d = H_ACK;
      end
      H_ACK: state_d = H_RUN;
      H_RUN: begin
        // termination only after the first word
        if (first_q & ~dmarq_s) begin
          state_d = H_TSTOP;
        end else if (first_q & stop_req_q) begin
          state_d = H_TPAUSE;
        end
      end
      H_TPAUSE: if (cnt_q >= RP_C) begin
        state_d = H_TSTOP;
      end
      H_TSTOP: if (~dmarq_s & (cnt_q >= ZAH_C)) begin
        state_d = H_TCRC;
      end
      H_TCRC: if (stb_s & (cnt_q >= MLI_C)) begin
        state_d = H_POST;
      end
      H_POST: if (cnt_q >= ACK_C) begin
        state_d = H_IDLE;
      end
      default: state_d = H_IDLE;
    endcase
  end

  // state, timer and burst flags
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_q <= H_IDLE;
      cnt_q <= '0;
      stb_p_q <= 1'b1;
      first_q <= 1'b0;
      stop_req_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stb_p_q <= stb_s;
      cnt_q <= (leave | (state_q == H_TSTOP & dmarq_s)) ? '0 : udb_sat_inc(cnt_q);
      first_q <= (state_q != H_IDLE) & (first_q | (take & ~stb_s));
      stop_req_q <= STOP_REQ_IN | (stop_req_q & ~(state_q == H_POST & leave));
      done_q <= (state_q == H_POST) & leave;
    end
  end

  // control pins follow the next state
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      dmack_n_q <= 1'b1;
      stop_q <= 1'b0;
      hrdy_n_q <= 1'b1;
      cs_n_q <= 2'h3;
      da_q <= 3'h0;
    end else begin
      // acknowledge only from setup end to post
      dmack_n_q <= ~((state_d == H_ACK) | (state_d == H_RUN) | (state_d == H_TPAUSE) |
                     (state_d == H_TSTOP) | (state_d == H_TCRC));
      // stop dropped once acknowledge is out
      stop_q <= (state_d == H_SETUP) | (state_d == H_ACK) | (state_d == H_TSTOP) |
                (state_d == H_TCRC) | (state_d == H_POST);
      // ready held until first word, then follows fifo space
      hrdy_n_q <= ~((state_d == H_RUN) & (~first_q | space_ok));
      cs_n_q <= (state_d == H_IDLE) ? CS_N_IN : 2'h3;
      da_q <= (state_d == H_IDLE) ? DA_IN : 3'h0;
    end
  end

  // crc of received words and crc drive
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      crc_q <= `UDB_CRC_SEED;
      dd_q <= '0;
      dd_oe_q <= 1'b0;
    end else begin
      if (state_q == H_IDLE) begin
        crc_q <= `UDB_CRC_SEED;
      end else if (take) begin
        crc_q <= udb_crc_next(crc_q, sync_w[15:0]);
      end
      if (state_q == H_TSTOP) begin
        dd_q <= crc_q;
      end
      // bus driven only for the crc
      dd_oe_q <= (state_d == H_TCRC) | (state_d == H_POST);
    end
  end

  // outputs
  assign LINK.dmack_n = dmack_n_q;
  assign LINK.stop = stop_q;
  assign LINK.hdmardy_n = hrdy_n_q;
  assign LINK.cs0_n = cs_n_q[0];
  assign LINK.cs1_n = cs_n_q[1];
  assign LINK.da = da_q;
  assign LINK.dd_host_o = dd_q;
  assign LINK.dd_host_oe = dd_oe_q;
  assign BUSY_OUT = (state_q != H_IDLE);
  assign DONE_OUT = done_q;
endmodule // udb_host

// [verilog/udb_if.sv]
// link pins between storage device and host with resolved bus levels
`timescale 1ns/1ns
`include "udb_cfg.svh"
interface udb_if;
  import udb_pkg::*;
  logic dmarq;
  logic dmack_n;
  logic stop;
  logic hdmardy_n;
  logic cs0_n;
  logic cs1_n;
  logic [2:0] da;
  logic dstrobe_o;
  logic dstrobe_oe;
  logic dstrobe;
  udb_word_t dd_dev_o;
  logic dd_dev_oe;
  udb_word_t dd_host_o;
  logic dd_host_oe;
  udb_word_t dd;

  // undriven strobe and bus float high
  assign dstrobe = dstrobe_oe ? dstrobe_o : 1'b1;
  assign dd = dd_dev_oe ? dd_dev_o : (dd_host_oe ? dd_host_o : `UDB_DD_IDLE);

  modport dev (
    input dmack_n, stop, hdmardy_n, dd,
    output dmarq, dstrobe_o, dstrobe_oe, dd_dev_o, dd_dev_oe
  );
  modport host (
    input dmarq, dstrobe, dd,
    output dmack_n, stop, hdmardy_n, cs0_n, cs1_n, da, dd_host_o, dd_host_oe
  );
endinterface

// [verilog/udb_pkg.sv]
// types and helpers shared by both ends of the data-in burst link
`include "udb_cfg.svh"
package udb_pkg;
  typedef logic [15:0] udb_word_t;
  typedef logic [7:0] udb_cnt_t;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_REQ = 6'h02,
    D_ARM = 6'h04,
    D_RUN = 6'h08,
    D_DRAIN = 6'h10,
    D_TERM = 6'h20
  } udb_dev_e;

  typedef enum logic [7:0] {
    H_IDLE = 8'h01,
    H_SETUP = 8'h02,
    H_ACK = 8'h04,
    H_RUN = 8'h08,
    H_TPAUSE = 8'h10,
    H_TSTOP = 8'h20,
    H_TCRC = 8'h40,
    H_POST = 8'h80
  } udb_host_e;

  // crc over one 16-bit word, msb first
  function automatic udb_word_t udb_crc_next(input udb_word_t crc, input udb_word_t d);
    udb_word_t c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ `UDB_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // saturating cycle counter step
  function automatic udb_cnt_t udb_sat_inc(input udb_cnt_t x);
    return (&x) ? x : x + 8'h01;
  endfunction
endpackage
